// ### common/cpu_ctrl_defines.svh
// Constants for the processor interrupt, reset and stall sequencer
`ifndef CPU_CTRL_DEFINES_SVH
`define CPU_CTRL_DEFINES_SVH

// Vector addresses, low byte first
`define VEC_NMI_LO 16'hFFFA
`define VEC_RST_LO 16'hFFFC
`define VEC_IRQ_LO 16'hFFFE

// Stack page and idle bus address
`define STACK_PAGE 8'h01
`define IDLE_ADDR 16'hFFFF

// Status register bit positions
`define STAT_IMASK_BIT 2
`define STAT_OVF_BIT 6

// Bus cycles of initialisation after reset release
`define RST_INIT_CYCLES 3'h6

`endif

// ### common/cpu_ctrl_pkg.sv
// Types shared by the processor interrupt, reset and stall sequencer
package cpu_ctrl_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_RST_INIT,
    ST_PUSH_PCH,
    ST_PUSH_PCL,
    ST_PUSH_P,
    ST_VEC_LO,
    ST_VEC_HI,
    ST_RESUME
  } seq_state_e;

  // Vector selection
  typedef enum logic [1:0] {
    VSEL_NMI,
    VSEL_RST,
    VSEL_IRQ
  } vec_sel_e;

  // Cycle request from the execution core
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic opfetch;
    logic last;
  } core_req_s;

  // Bus cycle presented on the pins
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic sync;
  } bus_cycle_s;

endpackage : cpu_ctrl_pkg

// ### design/phase_two_sampler.sv
// Phase-two sampling of interrupt and overflow-set inputs, with edge detection of NMI and overflow-set
`timescale 1ns/1ps
`default_nettype none

module phase_two_sampler (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Sample strobe, high in phase two
  input wire logic sample_i,
  // External active-low inputs
  input wire logic nmi_n_i,
  input wire logic irq_n_i,
  input wire logic so_n_i,
  // Conditioned outputs
  output logic nmi_edge_o,
  output logic irq_active_o,
  output logic so_edge_o
);

  logic nmi_prev_reg, nmi_prev_next;
  logic so_prev_reg, so_prev_next;
  logic nmi_edge_reg, nmi_edge_next;
  logic irq_reg, irq_next;
  logic so_edge_reg, so_edge_next;

  // =====================================================
  // Next values: sample only in phase two
  always_comb begin
    nmi_prev_next = nmi_prev_reg;
    so_prev_next = so_prev_reg;
    irq_next = irq_reg;
    nmi_edge_next = 1'b0;
    so_edge_next = 1'b0;
    if (sample_i) begin
      nmi_prev_next = nmi_n_i;
      so_prev_next = so_n_i;
      irq_next = ~irq_n_i;
      nmi_edge_next = nmi_prev_reg & ~nmi_n_i;
      so_edge_next = so_prev_reg & ~so_n_i;
    end
  end

  // =====================================================
  // State registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nmi_prev_reg <= 1'b1;
      so_prev_reg <= 1'b1;
      irq_reg <= 1'b0;
      nmi_edge_reg <= 1'b0;
      so_edge_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_prev_next;
      so_prev_reg <= so_prev_next;
      irq_reg <= irq_next;
      nmi_edge_reg <= nmi_edge_next;
      so_edge_reg <= so_edge_next;
    end
  end

  assign nmi_edge_o = nmi_edge_reg;
  assign irq_active_o = irq_reg;
  assign so_edge_o = so_edge_reg;

endmodule : phase_two_sampler

`default_nettype wire

// ### design/cpu_interrupt_reset_stall_control.sv
// Processor bus cycle sequencer: ready stall, interrupt entry and reset start-up
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ctrl_defines.svh"

module cpu_interrupt_reset_stall_control
  import cpu_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // External control inputs
  input wire logic ready_i,
  input wire logic irq_n_i,
  input wire logic nmi_n_i,
  input wire logic so_n_i,
  // Read data bus
  input wire logic [7:0] data_i,
  // Execution core state
  input var core_req_s core_req_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] sp_i,
  input wire logic [7:0] status_i,
  // Bus cycle and phase outputs
  output bus_cycle_s bus_o,
  output logic phase2_o,
  output logic halted_o,
  // Core handshake outputs
  output logic cycle_done_o,
  output logic seq_busy_o,
  output logic pc_load_o,
  output logic [15:0] pc_vec_o,
  output logic stack_push3_o,
  output logic imask_set_o,
  output logic ovf_set_o
);

  // =====================================================
  // Declarations
  seq_state_e state_reg, state_next;
  vec_sel_e vsel_reg, vsel_next;
  bus_cycle_s bus_reg, bus_next;
  logic last_reg, last_next;
  logic phase_reg, phase_next;
  logic halt_reg, halt_next;
  logic [2:0] init_cnt_reg, init_cnt_next;
  logic nmi_pend_reg, nmi_pend_next;
  logic [7:0] vec_lo_reg, vec_lo_next;
  logic [15:0] pc_vec_reg, pc_vec_next;
  logic done_reg, done_next;
  logic busy_reg, busy_next;
  logic pc_load_reg, pc_load_next;
  logic push3_reg, push3_next;
  logic imask_reg, imask_next;
  logic ovf_reg, ovf_next;
  logic cyc_end;
  logic nmi_edge;
  logic irq_active;
  logic so_edge;

  // =====================================================
  // Vector address for a selection, low or high byte
  function automatic logic [15:0] vec_addr(input vec_sel_e sel, input logic hi);
    logic [15:0] base;
    base = `VEC_IRQ_LO;
    case (sel)
      VSEL_NMI: base = `VEC_NMI_LO;
      VSEL_RST: base = `VEC_RST_LO;
      VSEL_IRQ: base = `VEC_IRQ_LO;
      default: base = `VEC_IRQ_LO;
    endcase
    return {base[15:1], hi};
  endfunction : vec_addr

  // Stack address at or below the current pointer
  function automatic logic [15:0] stack_addr(input logic [7:0] sp, input logic [1:0] off);
    logic [7:0] low;
    low = sp - {6'h00, off};
    return {`STACK_PAGE, low};
  endfunction : stack_addr

  // Build one bus cycle
  function automatic bus_cycle_s make_cycle(input logic [15:0] addr, input logic [7:0] wdata,
                                            input logic write, input logic sync);
    bus_cycle_s c;
    c.addr = addr;
    c.wdata = wdata;
    c.write = write;
    c.sync = sync;
    return c;
  endfunction : make_cycle

  // =====================================================
  // Input conditioning in phase two
  phase_two_sampler u_sampler (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .sample_i(phase_reg),
    .nmi_n_i(nmi_n_i),
    .irq_n_i(irq_n_i),
    .so_n_i(so_n_i),
    .nmi_edge_o(nmi_edge),
    .irq_active_o(irq_active),
    .so_edge_o(so_edge)
  );

  // =====================================================
  // Cycle end: phase two with ready high, writes never wait
  assign cyc_end = phase_reg & (ready_i | bus_reg.write);

  // =====================================================
  // Phase and halt next values
  always_comb begin
    phase_next = phase_reg;
    halt_next = halt_reg;
    if (!phase_reg) begin
      phase_next = 1'b1;
      halt_next = ~ready_i & ~bus_reg.write;
    end else if (cyc_end) begin
      phase_next = 1'b0;
      halt_next = 1'b0;
    end else begin
      halt_next = 1'b1;
    end
  end

  // =====================================================
  // Sequencer next values
  always_comb begin
    state_next = state_reg;
    vsel_next = vsel_reg;
    bus_next = bus_reg;
    last_next = last_reg;
    init_cnt_next = init_cnt_reg;
    vec_lo_next = vec_lo_reg;
    pc_vec_next = pc_vec_reg;
    nmi_pend_next = nmi_pend_reg;
    done_next = 1'b0;
    pc_load_next = 1'b0;
    push3_next = 1'b0;
    imask_next = 1'b0;
    ovf_next = so_edge;
    if (cyc_end) begin
      case (state_reg)
        ST_RUN, ST_RESUME: begin
          // Entry decided only at instruction end with ready high
          if (state_reg == ST_RUN && last_reg && ready_i && nmi_pend_reg) begin
            nmi_pend_next = 1'b0;
            vsel_next = VSEL_NMI;
            state_next = ST_PUSH_PCH;
            bus_next = make_cycle(stack_addr(sp_i, 2'h0), pc_i[15:8], 1'b1, 1'b0);
            last_next = 1'b0;
          end else if (state_reg == ST_RUN && last_reg && ready_i && irq_active
                       && !status_i[`STAT_IMASK_BIT]) begin
            vsel_next = VSEL_IRQ;
            state_next = ST_PUSH_PCH;
            bus_next = make_cycle(stack_addr(sp_i, 2'h0), pc_i[15:8], 1'b1, 1'b0);
            last_next = 1'b0;
          end else begin
            // Take the core's next cycle
            state_next = ST_RUN;
            bus_next = make_cycle(core_req_i.addr, core_req_i.wdata, core_req_i.write,
                                  core_req_i.opfetch);
            last_next = core_req_i.last;
            done_next = 1'b1;
          end
        end
        ST_RST_INIT: begin
          if (init_cnt_reg == `RST_INIT_CYCLES - 3'h1) begin
            vsel_next = VSEL_RST;
            imask_next = 1'b1;
            state_next = ST_VEC_LO;
            bus_next = make_cycle(vec_addr(VSEL_RST, 1'b0), 8'h00, 1'b0, 1'b0);
          end else begin
            init_cnt_next = init_cnt_reg + 3'h1;
          end
        end
        ST_PUSH_PCH: begin
          state_next = ST_PUSH_PCL;
          bus_next = make_cycle(stack_addr(sp_i, 2'h1), pc_i[7:0], 1'b1, 1'b0);
        end
        ST_PUSH_PCL: begin
          state_next = ST_PUSH_P;
          bus_next = make_cycle(stack_addr(sp_i, 2'h2), status_i, 1'b1, 1'b0);
        end
        ST_PUSH_P: begin
          push3_next = 1'b1;
          imask_next = 1'b1;
          state_next = ST_VEC_LO;
          bus_next = make_cycle(vec_addr(vsel_reg, 1'b0), 8'h00, 1'b0, 1'b0);
        end
        ST_VEC_LO: begin
          vec_lo_next = data_i;
          state_next = ST_VEC_HI;
          bus_next = make_cycle(vec_addr(vsel_reg, 1'b1), 8'h00, 1'b0, 1'b0);
        end
        ST_VEC_HI: begin
          pc_vec_next = {data_i, vec_lo_reg};
          pc_load_next = 1'b1;
          state_next = ST_RESUME;
          bus_next = make_cycle({data_i, vec_lo_reg}, 8'h00, 1'b0, 1'b0);
        end
        default: begin
          state_next = ST_RST_INIT;
          init_cnt_next = 3'h0;
          bus_next = make_cycle(`IDLE_ADDR, 8'h00, 1'b0, 1'b0);
        end
      endcase
    end
    // A new edge wins over the clear of a request just taken
    if (nmi_edge) begin
      nmi_pend_next = 1'b1;
    end
    busy_next = (state_next != ST_RUN);
  end

  // =====================================================
  // Phase and halt registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      halt_reg <= halt_next;
    end
  end

  // =====================================================
  // Sequencer registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_RST_INIT;
      vsel_reg <= VSEL_RST;
      bus_reg <= '{addr: `IDLE_ADDR, wdata: 8'h00, write: 1'b0, sync: 1'b0};
      last_reg <= 1'b0;
      init_cnt_reg <= 3'h0;
      vec_lo_reg <= 8'h00;
      pc_vec_reg <= 16'h0000;
      nmi_pend_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b1;
      pc_load_reg <= 1'b0;
      push3_reg <= 1'b0;
      imask_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      vsel_reg <= vsel_next;
      bus_reg <= bus_next;
      last_reg <= last_next;
      init_cnt_reg <= init_cnt_next;
      vec_lo_reg <= vec_lo_next;
      pc_vec_reg <= pc_vec_next;
      nmi_pend_reg <= nmi_pend_next;
      done_reg <= done_next;
      busy_reg <= busy_next;
      pc_load_reg <= pc_load_next;
      push3_reg <= push3_next;
      imask_reg <= imask_next;
      ovf_reg <= ovf_next;
    end
  end

  // =====================================================
  // Outputs straight from registers
  assign bus_o = bus_reg;
  assign phase2_o = phase_reg;
  assign halted_o = halt_reg;
  assign cycle_done_o = done_reg;
  assign seq_busy_o = busy_reg;
  assign pc_load_o = pc_load_reg;
  assign pc_vec_o = pc_vec_reg;
  assign stack_push3_o = push3_reg;
  assign imask_set_o = imask_reg;
  assign ovf_set_o = ovf_reg;

endmodule : cpu_interrupt_reset_stall_control

`default_nettype wire

// ### sim/cpu_ctrl_asserts.sv
// Checker for the stall, interrupt and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_ctrl_asserts
  import cpu_ctrl_pkg::*;
(
  // Watched signals
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic ready_i,
  input wire logic so_n_i,
  input wire logic [7:0] sp_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] status_i,
  input var bus_cycle_s bus_o,
  input wire logic phase2_o,
  input wire logic halted_o,
  input wire logic stack_push3_o,
  input wire logic imask_set_o,
  input wire logic ovf_set_o
);
  // ====================
  // Properties
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_vec_lo;
    !bus_o.write && bus_o.addr inside {16'hFFFA, 16'hFFFC, 16'hFFFE};
  endsequence
  sequence s_vec_hi;
    !bus_o.write && bus_o.addr == $past(bus_o.addr, 2) + 16'h0001;
  endsequence
  property p_halt; halted_o |-> $stable(bus_o.addr); endproperty
  a_halt: assert property (p_halt) else $error("address moved while halted");
  property p_stall; phase2_o && !ready_i && !bus_o.write |=> phase2_o && $stable(bus_o); endproperty
  a_stall: assert property (p_stall) else $error("read ended with ready low");
  property p_wr; bus_o.write |-> !halted_o; endproperty
  a_wr: assert property (p_wr) else $error("write cycle halted");
  property p_sync; bus_o.sync && !phase2_o |=> bus_o.sync && phase2_o; endproperty
  a_sync: assert property (p_sync) else $error("sync dropped in phase two");
  property p_vec; imask_set_o |-> s_vec_lo ##2 s_vec_hi; endproperty
  a_vec: assert property (p_vec) else $error("vector fetch wrong");
  property p_push;
    stack_push3_o |-> imask_set_o && $past(bus_o.write) && $past(bus_o.addr) == {8'h01, sp_i - 8'h02}
      && $past(bus_o.write, 5) && $past(bus_o.addr, 5) == {8'h01, sp_i}
      && $past(bus_o.addr, 3) == {8'h01, sp_i - 8'h01}
      && $past(bus_o.wdata, 5) == pc_i[15:8] && $past(bus_o.wdata, 3) == pc_i[7:0]
      && $past(bus_o.wdata) == status_i;
  endproperty
  a_push: assert property (p_push) else $error("stack pushes wrong");
  property p_rst_quiet; disable iff (1'b0) !reset_n_i |-> !bus_o.write && !imask_set_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("write during reset");
  property p_rst_seq; $rose(reset_n_i) |-> !imask_set_o [*8] ##1 !imask_set_o [*4] ##1 imask_set_o; endproperty
  a_rst_seq: assert property (p_rst_seq) else $error("reset start-up length wrong");
  property p_so; $fell(so_n_i) |-> ##[1:6] ovf_set_o; endproperty
  a_so: assert property (p_so) else $error("overflow set missing");
endmodule : cpu_ctrl_asserts
bind cpu_interrupt_reset_stall_control cpu_ctrl_asserts chk (.mclk_i, .reset_n_i, .ready_i, .so_n_i, .sp_i,
  .pc_i, .status_i,
  .bus_o, .phase2_o, .halted_o, .stack_push3_o, .imask_set_o, .ovf_set_o);
`default_nettype wire

// ### sim/vec_memory_model.sv
// Memory model answering the sequencer's read cycles
`timescale 1ns/1ps
`default_nettype none
module vec_memory_model
  import cpu_ctrl_pkg::*;
(
  // Clock and bus cycle
  input wire logic mclk_i,
  input var bus_cycle_s bus_i,
  // Read data
  output logic [7:0] data_o
);
  // Data from the address; a released bus turns over each write clock
  always_ff @(posedge mclk_i) begin
    data_o <= bus_i.write ? ~data_o : bus_i.addr[7:0] ^ 8'h5A;
  end
endmodule : vec_memory_model
`default_nettype wire

// ### sim/cpu_interrupt_reset_stall_control_tb.sv
// Bench for the stall, interrupt and reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ctrl_defines.svh"
module cpu_interrupt_reset_stall_control_tb
  import cpu_ctrl_pkg::*;
;
  // ====================
  // Signals
  logic mclk_i = 0, reset_n_i = 1, ready_i = 1, irq_n_i = 1, nmi_n_i = 1, so_n_i = 1;
  logic [7:0] data_i, sp_i = 8'hFF, status_i = 8'h00;
  logic [15:0] pc_i = 16'h1234, n = 16'h0000, pc_vec_o;
  core_req_s core_req_i;
  bus_cycle_s bus_o;
  logic phase2_o, halted_o, cycle_done_o, seq_busy_o, pc_load_o, stack_push3_o, imask_set_o, ovf_set_o;
  int num_errors = 0, tests_run = 0, pushes = 0;
  cpu_interrupt_reset_stall_control uut (.mclk_i, .reset_n_i, .ready_i, .irq_n_i, .nmi_n_i, .so_n_i, .data_i,
    .core_req_i, .pc_i, .sp_i, .status_i, .bus_o, .phase2_o, .halted_o, .cycle_done_o, .seq_busy_o, .pc_load_o,
    .pc_vec_o, .stack_push3_o, .imask_set_o, .ovf_set_o);
  vec_memory_model mem (.mclk_i, .bus_i(bus_o), .data_o(data_i));
  initial forever #12.5 mclk_i = ~mclk_i;
  // Core side: two-cycle instructions, every fourth cycle a write
  assign core_req_i = '{addr: 16'h0200 + n, wdata: n[7:0], write: n[1:0] == 2'h3, opfetch: !n[0], last: n[0]};
  always @(posedge mclk_i) begin
    if (cycle_done_o === 1'b1) n <= n + 16'h0001;
    if (stack_push3_o === 1'b1) sp_i <= sp_i - 8'h03;
    if (stack_push3_o === 1'b1) pushes <= pushes + 1;
    if (imask_set_o === 1'b1) status_i[2] <= 1'b1;
    if (ovf_set_o === 1'b1) status_i[6] <= 1'b1;
    if (pc_load_o === 1'b1) pc_i <= pc_vec_o;
  end
  // ====================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] vec(input logic [15:0] lo);
    return {(lo[7:0] + 8'h01) ^ 8'h5A, lo[7:0] ^ 8'h5A};
  endfunction : vec
  task automatic wait_load(input logic [15:0] exp);
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while (pc_load_o !== 1'b1 && k < 400);
    chk(16'(pc_load_o), 16'h0001);
    chk(pc_vec_o, exp);
  endtask : wait_load
  task automatic seek(input logic wr);
    int k;
    k = 0;
    do begin
      @(posedge mclk_i);
      #1;
      k++;
    end while (!(phase2_o === 1'b0 && (wr ? bus_o.write : bus_o.sync) === 1'b1) && k < 200);
  endtask : seek
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // ====================
  // Scenarios
  task automatic test_irq();
    int p;
    logic [15:0] a;
    p = pushes;
    @(posedge mclk_i) irq_n_i <= 1'b0;
    repeat (40) @(posedge mclk_i);
    chk(16'(pushes), 16'(p));
    // Stall the opcode fetch of an instruction that ends in a write
    do seek(1'b0); while (n[1:0] != 2'h2);
    a = bus_o.addr;
    @(posedge mclk_i) ready_i <= 1'b0;
    status_i[2] <= 1'b0;
    repeat (8) begin
      @(posedge mclk_i);
      #1 chk(bus_o.addr, a);
    end
    chk(16'({bus_o.sync, halted_o}), 16'h0003);
    chk(16'(pushes), 16'(p));
    @(posedge mclk_i) ready_i <= 1'b1;
    // Ready low again as the closing write ends with a request pending
    @(posedge mclk_i) ready_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    #1 chk(16'({bus_o.sync, seq_busy_o}), 16'h0002);
    @(posedge mclk_i) ready_i <= 1'b1;
    wait_load(vec(`VEC_IRQ_LO));
    chk(16'(pushes), 16'(p + 1));
    chk(16'(status_i[2]), 16'h0001);
    @(posedge mclk_i) irq_n_i <= 1'b1;
  endtask : test_irq
  task automatic test_nmi();
    int p;
    p = pushes;
    @(posedge mclk_i) nmi_n_i <= 1'b0;
    wait_load(vec(`VEC_NMI_LO));
    repeat (60) @(posedge mclk_i);
    chk(16'(pushes), 16'(p + 1));
    @(posedge mclk_i) nmi_n_i <= 1'b1;
    status_i[2] <= 1'b0;
    // High for two clocks so that a phase-two sample sees it
    repeat (2) @(posedge mclk_i);
    nmi_n_i <= 1'b0;
    irq_n_i <= 1'b0;
    wait_load(vec(`VEC_NMI_LO));
    @(posedge mclk_i) nmi_n_i <= 1'b1;
    irq_n_i <= 1'b1;
  endtask : test_nmi
  task automatic test_write_ready();
    seek(1'b1);
    @(posedge mclk_i) ready_i <= 1'b0;
    #1 chk(16'(halted_o), 16'h0000);
    repeat (4) @(posedge mclk_i);
    #1 chk(16'({bus_o.write, halted_o}), 16'h0001);
    @(posedge mclk_i) ready_i <= 1'b1;
  endtask : test_write_ready
  task automatic test_so();
    @(posedge mclk_i) so_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    #1 chk(16'(status_i[6]), 16'h0001);
    @(posedge mclk_i) so_n_i <= 1'b1;
  endtask : test_so
  // Main sequence
  initial begin
    // Clean falling edge at time zero so the design never shows unknowns
    reset_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    chk(bus_o.addr, `IDLE_ADDR);
    chk(16'(bus_o.write), 16'h0000);
    reset_n_i <= 1'b1;
    wait_load(vec(`VEC_RST_LO));
    chk(16'(status_i[2]), 16'h0001);
    test_irq();
    test_nmi();
    test_write_ready();
    test_so();
    report_and_stop();
  end
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule : cpu_interrupt_reset_stall_control_tb
`default_nettype wire
